// File: logic/mbo_pkg.sv
package mbo_pkg;
  localparam logic [7:0] ADDR_CONVERSION_RESULT = 8'h00;
  localparam int RESULT_W = 24;
  localparam logic [3:0] COMP_PLUS2 = 4'b1111;
  localparam logic [3:0] COMP_PLUS1 = 4'b0111;
  localparam logic [3:0] COMP_ZERO = 4'b0011;
  localparam logic [3:0] COMP_MINUS1 = 4'b0001;
  localparam logic [3:0] COMP_MINUS2 = 4'b0000;
  localparam logic [1:0] CLK_SEL_EXT = 2'b00;
  localparam logic [1:0] CLK_SEL_INT_OUT = 2'b11;
  localparam logic [1:0] BIAS_RESET = 2'b10;
  localparam logic [2:0] GAIN_16X = 3'b101;
  localparam int SYNC_PERIODS = 2;
  localparam int COMP_BITS = 4;
  localparam int ANALOG_MASTER_CLOCK_DIV_DEFAULT = 4;
  localparam int MCLK_PER_ANALOG_MASTER_CLOCK_DEFAULT = 4;
  typedef enum logic [1:0] {
    MBO_IDLE = 2'b00,
    MBO_SYNC = 2'b01,
    MBO_RUN = 2'b11
  } mbo_state_t;
endpackage

// File: logic/mbo_clkdiv.sv
`timescale 1ns/10ps
module mbo_clkdiv #(
  parameter int DIV = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic restart,
  output logic tick
);
  logic [15:0] cnt_q;

  always_ff @(posedge clk) begin
    if (srst || restart) begin
      cnt_q <= '0;
    end else if (cnt_q == 16'(DIV - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign tick = (cnt_q == 16'(DIV - 1));
endmodule

// File: logic/mbo_modulator_out.sv
`timescale 1ns/10ps
// Functional notes
// - Gain above 16x: analog 16x, digital left shift
// - One new 5-level result per sampling clock
// - Mode bit drives stream pin, mirrors data register
// - Stream mode disables filter and data-ready interrupt
// - Stream mode always drives the shared pin
// - Four comparator bits shifted, one per analog clock
// - Thermometer coding of the five levels
// - Clock select 11 drives analog clock out
// - Reset value of modulator output is 0011
// - Restart holds pin high two clocks, then zero
// - Two-bit bias select scales modulator bias current
module mbo_modulator_out #(
  parameter int ANALOG_MASTER_CLOCK_DIV = mbo_pkg::ANALOG_MASTER_CLOCK_DIV_DEFAULT,
  parameter int MCLK_PER_ANALOG_MASTER_CLOCK = mbo_pkg::MCLK_PER_ANALOG_MASTER_CLOCK_DEFAULT
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic master_clock_in,
  input wire logic [1:0] clock_source_select,
  input wire logic [1:0] interrupt_mode,
  input wire logic [2:0] gain_select,
  input wire logic [1:0] bias_current_select,
  input wire logic converter_restart,
  input wire logic signed [2:0] quantizer_level,
  input wire logic [23:0] filter_code,
  input wire logic filter_data_ready,
  input wire logic [7:0] reg_addr,
  input wire logic reg_read,
  output logic [23:0] reg_rdata,
  output logic interrupt_or_bitstream_pin_o,
  output logic interrupt_or_bitstream_pin_oe,
  output logic master_clock_pin_o,
  output logic master_clock_pin_oe,
  output logic filter_enable,
  output logic data_ready_irq_n,
  output logic [2:0] analog_gain_code,
  output logic [1:0] digital_shift,
  output logic [1:0] bias_scale_code,
  output logic [23:0] scaled_code
);
  logic mclk_s1_q;
  logic mclk_s2_q;
  logic mclk_s3_q;
  logic mclk_rise;
  logic stream_mode;
  logic analog_master_clock_tick;
  logic analog_master_clock_q;
  logic [3:0] shift_q;
  logic [1:0] bit_cnt_q;
  logic [1:0] sync_cnt_q;
  logic [3:0] result_q;
  logic sample_tick;
  logic [7:0] analog_master_clock_cnt_q;
  logic pin_q;
  logic [1:0] bias_q;
  logic bit_step;
  logic [3:0] level_code;
  mbo_pkg::mbo_state_t state_q;

  function automatic logic [3:0] thermo(input logic signed [2:0] lvl);
    if (lvl >= 3'sd2) begin
      thermo = mbo_pkg::COMP_PLUS2;
    end else if (lvl == 3'sd1) begin
      thermo = mbo_pkg::COMP_PLUS1;
    end else if (lvl == 3'sd0) begin
      thermo = mbo_pkg::COMP_ZERO;
    end else if (lvl == -3'sd1) begin
      thermo = mbo_pkg::COMP_MINUS1;
    end else begin
      thermo = mbo_pkg::COMP_MINUS2;
    end
  endfunction

  // The master clock pin is asynchronous; the second and third stages feed edge logic.
  always_ff @(posedge clk) begin
    if (srst) begin
      mclk_s1_q <= 1'b0;
      mclk_s2_q <= 1'b0;
      mclk_s3_q <= 1'b0;
    end else begin
      mclk_s1_q <= master_clock_in;
      mclk_s2_q <= mclk_s1_q;
      mclk_s3_q <= mclk_s2_q;
    end
  end
  assign mclk_rise = mclk_s2_q && !mclk_s3_q;

  assign stream_mode = interrupt_mode[1];

  mbo_clkdiv #(
    .DIV(ANALOG_MASTER_CLOCK_DIV)
  ) u_div (
    .clk(clk),
    .srst(srst),
    .restart(converter_restart),
    .tick(analog_master_clock_tick)
  );

  // With the external clock the analog clock follows input edges, divided by twice the ratio.
  logic analog_master_clock_step;
  always_ff @(posedge clk) begin
    if (srst || converter_restart) begin
      analog_master_clock_cnt_q <= 8'h00;
    end else if (mclk_rise) begin
      analog_master_clock_cnt_q <= (analog_master_clock_cnt_q == 8'(MCLK_PER_ANALOG_MASTER_CLOCK - 1)) ? 8'h00 : analog_master_clock_cnt_q + 8'h01;
    end
  end
  assign analog_master_clock_step = (clock_source_select == mbo_pkg::CLK_SEL_EXT) ?
    (mclk_rise && analog_master_clock_cnt_q == 8'(MCLK_PER_ANALOG_MASTER_CLOCK - 1)) : analog_master_clock_tick;

  // The analog clock falls where a new bit is launched, so a receiver that samples on its
  // rising edge sees each bit in mid-period; a restart also restarts its phase.
  always_ff @(posedge clk) begin
    if (srst || converter_restart) begin
      analog_master_clock_q <= 1'b0;
    end else if (analog_master_clock_step) begin
      analog_master_clock_q <= ~analog_master_clock_q;
    end
  end
  assign bit_step = analog_master_clock_step && analog_master_clock_q;
  assign level_code = thermo(quantizer_level);

  assign sample_tick = bit_step && (bit_cnt_q == 2'd3) && (state_q == mbo_pkg::MBO_RUN);

  always_ff @(posedge clk) begin
    if (srst) begin
      result_q <= mbo_pkg::COMP_ZERO;
    end else if (converter_restart) begin
      result_q <= mbo_pkg::COMP_ZERO;
    end else if (sample_tick) begin
      result_q <= level_code;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || converter_restart) begin
      state_q <= mbo_pkg::MBO_SYNC;
      sync_cnt_q <= 2'd0;
      bit_cnt_q <= 2'd0;
      shift_q <= mbo_pkg::COMP_ZERO;
      pin_q <= 1'b1;
    end else begin
      case (state_q)
        mbo_pkg::MBO_IDLE: begin
          state_q <= mbo_pkg::MBO_SYNC;
        end
        mbo_pkg::MBO_SYNC: begin
          pin_q <= 1'b1;
          if (bit_step) begin
            if (sync_cnt_q == 2'(mbo_pkg::SYNC_PERIODS - 1)) begin
              state_q <= mbo_pkg::MBO_RUN;
              shift_q <= {result_q[2:0], 1'b0};
              pin_q <= result_q[3];
              bit_cnt_q <= 2'd0;
            end else begin
              sync_cnt_q <= sync_cnt_q + 2'd1;
            end
          end
        end
        mbo_pkg::MBO_RUN: begin
          if (bit_step) begin
            bit_cnt_q <= bit_cnt_q + 2'd1;
            if (bit_cnt_q == 2'd3) begin
              pin_q <= level_code[3];
              shift_q <= {level_code[2:0], 1'b0};
            end else begin
              pin_q <= shift_q[3];
              shift_q <= {shift_q[2:0], 1'b0};
            end
          end
        end
        default: begin
          state_q <= mbo_pkg::MBO_SYNC;
        end
      endcase
    end
  end

  assign interrupt_or_bitstream_pin_o = stream_mode ? pin_q : data_ready_irq_n;
  assign interrupt_or_bitstream_pin_oe = 1'b1;
  assign filter_enable = !stream_mode;
  assign data_ready_irq_n = stream_mode ? 1'b1 : !filter_data_ready;

  assign master_clock_pin_o = analog_master_clock_q;
  assign master_clock_pin_oe = (clock_source_select == mbo_pkg::CLK_SEL_INT_OUT);

  always_comb begin
    if (gain_select > mbo_pkg::GAIN_16X) begin
      analog_gain_code = mbo_pkg::GAIN_16X;
      digital_shift = 2'(gain_select - mbo_pkg::GAIN_16X);
    end else begin
      analog_gain_code = gain_select;
      digital_shift = 2'd0;
    end
  end

  // Plain left shift with no rounding: the filter code is already final.
  always_ff @(posedge clk) begin
    if (srst) begin
      scaled_code <= '0;
    end else if (filter_data_ready) begin
      scaled_code <= filter_code << digital_shift;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bias_q <= mbo_pkg::BIAS_RESET;
    end else begin
      bias_q <= bias_current_select;
    end
  end
  assign bias_scale_code = bias_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      if (reg_addr == mbo_pkg::ADDR_CONVERSION_RESULT) begin
        reg_rdata <= stream_mode ? {20'h0_0000, result_q} : scaled_code;
      end else begin
        reg_rdata <= '0;
      end
    end
  end
endmodule

// File: tb/mbo_asserts.sv
`timescale 1ns/10ps
module mbo_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic [1:0] clock_source_select,
  input wire logic [1:0] interrupt_mode,
  input wire logic [2:0] gain_select,
  input wire logic converter_restart,
  input wire logic [7:0] reg_addr,
  input wire logic reg_read,
  input wire logic [23:0] reg_rdata,
  input wire logic interrupt_or_bitstream_pin_o,
  input wire logic interrupt_or_bitstream_pin_oe,
  input wire logic master_clock_pin_oe,
  input wire logic filter_enable,
  input wire logic data_ready_irq_n,
  input wire logic [2:0] analog_gain_code,
  input wire logic [1:0] digital_shift,
  input wire logic [1:0] bias_scale_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_pin_driven: assert property (interrupt_mode[1] |-> interrupt_or_bitstream_pin_oe)
    else $error("stream pin released");
  a_filter_off: assert property (interrupt_mode[1] |-> !filter_enable)
    else $error("filter left on");
  a_irq_quiet: assert property (interrupt_mode[1] |-> data_ready_irq_n)
    else $error("data ready raised");
  a_clock_out: assert property (clock_source_select == 2'h3 |-> master_clock_pin_oe)
    else $error("clock out not driven");
  a_gain_high: assert property (gain_select > 3'h5 |-> analog_gain_code == 3'h5 &&
    digital_shift == 2'(gain_select - 3'h5)) else $error("high gain split wrong");
  a_gain_low: assert property (gain_select <= 3'h5 |-> analog_gain_code == gain_select &&
    digital_shift == 2'h0) else $error("low gain split wrong");
  a_bias_reset: assert property ($past(srst) |-> bias_scale_code == 2'h2)
    else $error("bias reset value wrong");
  a_sync_high: assert property ($past(srst) && interrupt_mode[1] |->
    interrupt_or_bitstream_pin_o [*4]) else $error("sync level missing");
  a_restart_sync: assert property (converter_restart && interrupt_mode[1] |=>
    interrupt_or_bitstream_pin_o [*8]) else $error("restart sync level missing");
  a_unmapped_zero: assert property (reg_read && reg_addr != 8'h00 |=>
    reg_rdata == 24'h00_0000) else $error("unmapped read not zero");
  c_restart: cover property (converter_restart);
  c_gain_top: cover property (gain_select == 3'h7);
  c_result_read: cover property (reg_read && reg_addr == 8'h00);
endmodule
bind mbo_modulator_out mbo_asserts chk_u (.clk, .srst, .clock_source_select, .interrupt_mode,
  .gain_select, .converter_restart, .reg_addr, .reg_read, .reg_rdata,
  .interrupt_or_bitstream_pin_o, .interrupt_or_bitstream_pin_oe, .master_clock_pin_oe,
  .filter_enable, .data_ready_irq_n, .analog_gain_code, .digital_shift, .bias_scale_code);

// File: tb/mbo_filter_model.sv
`timescale 1ns/10ps
module mbo_filter_model (
  input wire logic clk,
  input wire logic clear,
  input wire logic stream_bit,
  input wire logic analog_clock,
  output logic [15:0] history,
  output logic [3:0] word
);
  logic seen_q;
  int cnt_q;
  // One sample per analog clock period, taken where that clock is seen rising.
  // After the two sync bits, every fourth sample completes one result word.
  always @(posedge clk) begin
    seen_q <= analog_clock;
    if (clear) begin
      history <= 16'h0000;
      cnt_q <= 0;
      word <= 4'h0;
    end else if (analog_clock && !seen_q) begin
      history <= {history[14:0], stream_bit};
      cnt_q <= cnt_q + 1;
      if (cnt_q >= 5 && cnt_q % 4 == 1) word <= {history[2:0], stream_bit};
    end
  end
endmodule

// File: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic [2:0] g;
    logic [2:0] ag;
    logic [1:0] sh;
    logic [2:0] l;
    logic [2:0] n;
    logic [3:0] t;
  } mbo_row_t;
  mbo_row_t rows [8] = '{'{3'h0, 3'h0, 2'h0, 3'h6, 3'h0, 4'h0}, '{3'h1, 3'h1, 2'h0, 3'h7, 3'h1, 4'h1},
    '{3'h2, 3'h2, 2'h0, 3'h0, 3'h2, 4'h3}, '{3'h3, 3'h3, 2'h0, 3'h1, 3'h3, 4'h7},
    '{3'h4, 3'h4, 2'h0, 3'h2, 3'h4, 4'hf}, '{3'h5, 3'h5, 2'h0, 3'h0, 3'h2, 4'h3},
    '{3'h6, 3'h5, 2'h1, 3'h1, 3'h3, 4'h7}, '{3'h7, 3'h5, 2'h2, 3'h6, 3'h0, 4'h0}};
  logic clk = 1'b0, srst = 1'b1, master_clock_in = 1'b0, converter_restart = 1'b0;
  logic [1:0] clock_source_select = 2'h3, interrupt_mode = 2'h2, bias_current_select = 2'h2;
  logic [2:0] gain_select = 3'h0;
  logic signed [2:0] quantizer_level = 3'h1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_read = 1'b0, clr = 1'b1;
  logic [23:0] reg_rdata;
  logic interrupt_or_bitstream_pin_o, interrupt_or_bitstream_pin_oe, master_clock_pin_o;
  logic master_clock_pin_oe, filter_enable, data_ready_irq_n;
  logic [2:0] analog_gain_code;
  logic [1:0] digital_shift, bias_scale_code;
  logic [15:0] history;
  logic [3:0] word;
  logic [23:0] filter_code = 24'h00_0123;
  logic [23:0] scaled_code;
  logic filter_data_ready = 1'b0;
  int failures = 0, n_checks = 0;
  always #50 clk = ~clk;
  initial begin
    #23;
    forever #400 master_clock_in = ~master_clock_in;
  end
  mbo_modulator_out #(.ANALOG_MASTER_CLOCK_DIV(4), .MCLK_PER_ANALOG_MASTER_CLOCK(4)) dut_u (.clk, .srst, .master_clock_in,
    .clock_source_select, .interrupt_mode, .gain_select, .bias_current_select, .converter_restart,
    .quantizer_level, .filter_code, .filter_data_ready, .reg_addr, .reg_read,
    .reg_rdata, .interrupt_or_bitstream_pin_o, .interrupt_or_bitstream_pin_oe,
    .master_clock_pin_o, .master_clock_pin_oe, .filter_enable, .data_ready_irq_n,
    .analog_gain_code, .digital_shift, .bias_scale_code, .scaled_code);
  mbo_filter_model far_u (.clk(clk), .clear(clr), .stream_bit(interrupt_or_bitstream_pin_o),
    .analog_clock(master_clock_pin_o), .history(history), .word(word));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
  endtask
  // Finds the first high sample captured since the last clear and takes ten bits from it.
  task automatic seq(input logic [9:0] exp);
    int k;
    k = 15;
    while (k > 9 && history[k] !== 1'b1) k--;
    chk(24'(history[k -: 10]), 24'(exp), "stream");
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #400_000;
    failures++;
    complete_run();
  end
  initial begin
    repeat (16) @(negedge clk);
    srst = 1'b0;
    clr = 1'b0;
    repeat (100) @(negedge clk);
    seq(10'h337);
    chk(24'(master_clock_pin_oe), 24'h00_0001, "clock out on");
    for (int i = 0; i < 8; i++) begin
      gain_select = rows[i].g;
      quantizer_level = rows[i].l;
      repeat (64) @(negedge clk);
      chk(24'(analog_gain_code), 24'(rows[i].ag), "analog gain");
      chk(24'(digital_shift), 24'(rows[i].sh), "digital shift");
      chk(24'($countones(word)), 24'(rows[i].n), "ones");
      chk(24'(word), 24'(rows[i].t), "stream word");
      rd(8'h00);
      chk(24'(reg_rdata[3:0]), 24'(rows[i].t), "result");
      filter_data_ready = 1'b1;
      @(negedge clk);
      chk(24'(data_ready_irq_n), 24'h00_0001, "irq quiet");
      filter_data_ready = 1'b0;
      @(negedge clk);
      chk(scaled_code, filter_code << rows[i].sh, "scaled");
    end
    clr = 1'b1;
    converter_restart = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    converter_restart = 1'b0;
    repeat (100) @(negedge clk);
    seq(10'h330);
    chk(24'(interrupt_or_bitstream_pin_oe), 24'h00_0001, "pin enable");
    clr = 1'b1;
    converter_restart = 1'b1;
    clock_source_select = 2'h0;
    @(negedge clk);
    clr = 1'b0;
    converter_restart = 1'b0;
    chk(24'(master_clock_pin_oe), 24'h00_0000, "clock out off");
    repeat (900) @(negedge clk);
    seq(10'h330);
    rd(8'h05);
    chk(reg_rdata, 24'h00_0000, "unmapped");
    bias_current_select = 2'h3;
    @(negedge clk);
    chk(24'(bias_scale_code), 24'h00_0003, "bias");
    clock_source_select = 2'h0;
    interrupt_mode = 2'h0;
    @(negedge clk);
    chk(24'(master_clock_pin_oe), 24'h00_0000, "clock out");
    chk(24'(filter_enable), 24'h00_0001, "filter");
    filter_data_ready = 1'b1;
    @(negedge clk);
    chk(24'(data_ready_irq_n), 24'h00_0000, "irq raised");
    filter_data_ready = 1'b0;
    complete_run();
  end
endmodule
